/* pkg/spfcs_pkg.sv */
// constants for the switch port flow control select register bank
package spfcs_pkg;
    localparam int SPFCS_ADDR_W = 12;
    localparam int SPFCS_DATA_W = 32;
    localparam int SPFCS_PORTS = 2;
    // register byte offsets
    localparam logic [11:0] SPFCS_PORT1_FC_OFS = 12'h1a0;
    localparam logic [11:0] SPFCS_PORT2_FC_OFS = 12'h1a4;
    // field positions
    localparam int SPFCS_BIT_SELECT = 0;
    localparam int SPFCS_BIT_TX_ALLOW = 1;
    localparam int SPFCS_BIT_RX_ALLOW = 2;
    localparam int SPFCS_BIT_TX_ACTIVE = 3;
    localparam int SPFCS_BIT_RX_ACTIVE = 4;
    localparam int SPFCS_BIT_DUPLEX = 5;
    localparam int SPFCS_BIT_BP = 6;
    localparam int SPFCS_RSV_LSB = 7;
    localparam logic [31:0] SPFCS_RDATA_RST = 32'h0000_0000;
    // pin sample layout, per port
    localparam int SPFCS_PIN_BP = 0;
    localparam int SPFCS_PIN_PAUSE = 1;
    localparam int SPFCS_PIN_SELECT = 2;
    localparam int SPFCS_PIN_ANEG_EN = 3;
    localparam int SPFCS_PIN_ANEG_RX = 4;
    localparam int SPFCS_PIN_ANEG_TX = 5;
    localparam int SPFCS_PIN_HALF = 6;
    localparam int SPFCS_PINS_PER_PORT = 7;
    localparam int SPFCS_PIN_W = 14;
    // last wait count, one below the two edges the synchroniser needs before pin samples are valid
    localparam logic [1:0] SPFCS_SYNC_WAIT = 2'h1;
    localparam logic [1:0] SPFCS_CNT_RST = 2'h0;
    // strap load sequencer, one-hot
    typedef enum logic [2:0] {
        SPFCS_ST_WAIT = 3'h1,
        SPFCS_ST_LOAD = 3'h2,
        SPFCS_ST_RUN = 3'h4
    } spfcs_state_t;
endpackage : spfcs_pkg

/* logic/spfcs_port_sel.sv */
// effective pause selection for one switch port
`timescale 1ns/10ps
module spfcs_port_sel (
    // software settings
    input wire logic i_select,
    input wire logic i_rx_allow,
    input wire logic i_tx_allow,
    // negotiation and link state
    input wire logic i_aneg_en,
    input wire logic i_aneg_rx,
    input wire logic i_aneg_tx,
    input wire logic i_half,
    // effective settings
    output logic o_rx_eff,
    output logic o_tx_eff
);
    always_comb begin
        o_rx_eff = 1'b0;
        o_tx_eff = 1'b0;
        if (i_select) begin
            o_rx_eff = i_rx_allow & ~i_half;
            o_tx_eff = i_tx_allow & ~i_half;
        end else if (i_aneg_en) begin
            o_rx_eff = i_aneg_rx;
            o_tx_eff = i_aneg_tx;
        end else begin
            o_rx_eff = i_rx_allow;
            o_tx_eff = i_tx_allow;
        end
    end
endmodule : spfcs_port_sel

/* logic/spfcs_top.sv */
// flow control select registers for switch ports 1 and 2
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
// Function
// - port 1 register at 1a0h, bits 31:7 reserved read-only
// - port 2 register at 1a4h, same layout and behaviour
// - bit 6 read-write, enables half-duplex backpressure
// - bit 5 read-only duplex, 0 full 1 half
// - bit 4 read-only, receive pause currently active
// - bit 3 read-only, transmit pause currently active
// - bit 2 read-write receive pause enable when software governs
// - bit 1 read-write transmit pause enable when software governs
// - select 0 with negotiation on: negotiated result, software bits ignored
// - select 0 with negotiation off: software bits apply
// - select 1: software bits govern in full duplex
// - writes never touch the advertised pause abilities
// - reads return the effective flow control state
// - writable bits load from per-port straps at reset
// - status reset value comes from several straps combined
module spfcs_top
    import spfcs_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // port 1 straps
    input wire logic i_port1_backpressure_pin_cfg,
    input wire logic i_port1_pause_pin_cfg,
    input wire logic i_port1_select_pin_cfg,
    // port 2 straps
    input wire logic i_port2_backpressure_pin_cfg,
    input wire logic i_port2_pause_pin_cfg,
    input wire logic i_port2_select_pin_cfg,
    // port 1 transceiver state
    input wire logic i_port1_aneg_enable,
    input wire logic i_port1_aneg_rx_pause,
    input wire logic i_port1_aneg_tx_pause,
    input wire logic i_port1_half_duplex,
    // port 2 transceiver state
    input wire logic i_port2_aneg_enable,
    input wire logic i_port2_aneg_rx_pause,
    input wire logic i_port2_aneg_tx_pause,
    input wire logic i_port2_half_duplex,
    // port 1 to switch engine
    output logic o_port1_rx_pause_active,
    output logic o_port1_tx_pause_active,
    output logic o_port1_backpressure_on,
    output logic o_port1_duplex_status,
    // port 2 to switch engine
    output logic o_port2_rx_pause_active,
    output logic o_port2_tx_pause_active,
    output logic o_port2_backpressure_on,
    output logic o_port2_duplex_status
);
    default clocking cb_mclk @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    // one-hot port hit, zero when unmapped
    function automatic logic [1:0] port_hit(input logic [11:0] addr);
        logic [1:0] hit;
        hit = 2'h0;
        if (addr == SPFCS_PORT1_FC_OFS) begin
            hit = 2'h1;
        end else if (addr == SPFCS_PORT2_FC_OFS) begin
            hit = 2'h2;
        end
        return hit;
    endfunction : port_hit

    function automatic logic [31:0] pack_word(input logic bp, input logic dup,
                                              input logic rxa, input logic txa,
                                              input logic rx, input logic tx,
                                              input logic sel);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SPFCS_BIT_BP] = bp;
        w[SPFCS_BIT_DUPLEX] = dup;
        w[SPFCS_BIT_RX_ACTIVE] = rxa;
        w[SPFCS_BIT_TX_ACTIVE] = txa;
        w[SPFCS_BIT_RX_ALLOW] = rx;
        w[SPFCS_BIT_TX_ALLOW] = tx;
        w[SPFCS_BIT_SELECT] = sel;
        return w;
    endfunction : pack_word

    // pin synchroniser
    logic [13:0] pin_raw;
    logic [13:0] pin_meta_reg;
    logic [13:0] pin_sync_reg;
    assign pin_raw = {i_port2_half_duplex, i_port2_aneg_tx_pause, i_port2_aneg_rx_pause,
                      i_port2_aneg_enable, i_port2_select_pin_cfg, i_port2_pause_pin_cfg,
                      i_port2_backpressure_pin_cfg,
                      i_port1_half_duplex, i_port1_aneg_tx_pause, i_port1_aneg_rx_pause,
                      i_port1_aneg_enable, i_port1_select_pin_cfg, i_port1_pause_pin_cfg,
                      i_port1_backpressure_pin_cfg};
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta_reg <= 14'h0000;
            pin_sync_reg <= 14'h0000;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // per-port views of the synchronised pins
    logic [1:0] strap_bp;
    logic [1:0] strap_pause;
    logic [1:0] strap_sel;
    logic [1:0] aneg_en;
    logic [1:0] aneg_rx;
    logic [1:0] aneg_tx;
    logic [1:0] half;

    always_comb begin
        for (int p = 0; p < SPFCS_PORTS; p++) begin
            strap_bp[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_BP];
            strap_pause[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_PAUSE];
            strap_sel[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_SELECT];
            aneg_en[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_ANEG_EN];
            aneg_rx[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_ANEG_RX];
            aneg_tx[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_ANEG_TX];
            half[p] = pin_sync_reg[p * SPFCS_PINS_PER_PORT + SPFCS_PIN_HALF];
        end
    end

    // strap load sequencer
    spfcs_state_t state_reg;
    spfcs_state_t state_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            SPFCS_ST_WAIT: begin
                cnt_next = 2'(cnt_reg + 2'h1);
                if (cnt_reg == SPFCS_SYNC_WAIT) begin
                    state_next = SPFCS_ST_LOAD;
                end
            end
            SPFCS_ST_LOAD: begin
                state_next = SPFCS_ST_RUN;
            end
            SPFCS_ST_RUN: begin
                state_next = SPFCS_ST_RUN;
            end
            default: begin
                state_next = SPFCS_ST_WAIT;
                cnt_next = SPFCS_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= SPFCS_ST_WAIT;
            cnt_reg <= SPFCS_CNT_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // writable fields
    logic [1:0] bp_reg;
    logic [1:0] rx_allow_reg;
    logic [1:0] tx_allow_reg;
    logic [1:0] sel_reg;
    logic [1:0] bp_next;
    logic [1:0] rx_allow_next;
    logic [1:0] tx_allow_next;
    logic [1:0] sel_next;
    logic [1:0] hit;
    assign hit = port_hit(i_addr);
    always_comb begin
        bp_next = bp_reg;
        rx_allow_next = rx_allow_reg;
        tx_allow_next = tx_allow_reg;
        sel_next = sel_reg;
        if (state_reg == SPFCS_ST_LOAD) begin
            bp_next = strap_bp;
            rx_allow_next = strap_pause;
            tx_allow_next = strap_pause;
            sel_next = strap_sel;
        end else if (state_reg == SPFCS_ST_RUN && i_wr) begin
            for (int p = 0; p < SPFCS_PORTS; p++) begin
                if (hit[p]) begin
                    bp_next[p] = i_wdata[SPFCS_BIT_BP];
                    rx_allow_next[p] = i_wdata[SPFCS_BIT_RX_ALLOW];
                    tx_allow_next[p] = i_wdata[SPFCS_BIT_TX_ALLOW];
                    sel_next[p] = i_wdata[SPFCS_BIT_SELECT];
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bp_reg <= 2'h0;
            rx_allow_reg <= 2'h0;
            tx_allow_reg <= 2'h0;
            sel_reg <= 2'h0;
        end else begin
            bp_reg <= bp_next;
            rx_allow_reg <= rx_allow_next;
            tx_allow_reg <= tx_allow_next;
            sel_reg <= sel_next;
        end
    end

    // effective selection per port
    logic [1:0] rx_eff;
    logic [1:0] tx_eff;
    for (genvar g = 0; g < SPFCS_PORTS; g++) begin : g_port
        spfcs_port_sel u_sel (
            .i_select(sel_reg[g]),
            .i_rx_allow(rx_allow_reg[g]),
            .i_tx_allow(tx_allow_reg[g]),
            .i_aneg_en(aneg_en[g]),
            .i_aneg_rx(aneg_rx[g]),
            .i_aneg_tx(aneg_tx[g]),
            .i_half(half[g]),
            .o_rx_eff(rx_eff[g]),
            .o_tx_eff(tx_eff[g])
        );
    end

    // status and engine outputs
    logic [1:0] rx_act_reg;
    logic [1:0] tx_act_reg;
    logic [1:0] dup_reg;
    logic [1:0] rx_act_next;
    logic [1:0] tx_act_next;
    logic [1:0] dup_next;
    always_comb begin
        rx_act_next = rx_act_reg;
        tx_act_next = tx_act_reg;
        dup_next = dup_reg;
        // status follows the effective selection and link state once the wait ends
        if (state_reg != SPFCS_ST_WAIT) begin
            rx_act_next = rx_eff;
            tx_act_next = tx_eff;
            dup_next = half;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_act_reg <= 2'h0;
            tx_act_reg <= 2'h0;
            dup_reg <= 2'h0;
        end else begin
            rx_act_reg <= rx_act_next;
            tx_act_reg <= tx_act_next;
            dup_reg <= dup_next;
        end
    end

    assign o_port1_rx_pause_active = rx_act_reg[0];
    assign o_port1_tx_pause_active = tx_act_reg[0];
    assign o_port1_backpressure_on = bp_reg[0];
    assign o_port1_duplex_status = dup_reg[0];
    assign o_port2_rx_pause_active = rx_act_reg[1];
    assign o_port2_tx_pause_active = tx_act_reg[1];
    assign o_port2_backpressure_on = bp_reg[1];
    assign o_port2_duplex_status = dup_reg[1];

    // read data, valid the cycle after the strobe only
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = SPFCS_RDATA_RST;
        if (i_rd) begin
            for (int p = 0; p < SPFCS_PORTS; p++) begin
                if (hit[p]) begin
                    rdata_next = pack_word(bp_reg[p], dup_reg[p], rx_act_reg[p],
                                           tx_act_reg[p], rx_allow_reg[p],
                                           tx_allow_reg[p], sel_reg[p]);
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= SPFCS_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign o_rdata = rdata_reg;
    // checks
    logic run;
    assign run = (state_reg == SPFCS_ST_RUN);
    property p_rsv_zero;
        i_rd |=> (o_rdata[31:SPFCS_RSV_LSB] == 25'h0);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
    property p_bp_write;
        (run && i_wr && i_addr == SPFCS_PORT1_FC_OFS)
            |=> (o_port1_backpressure_on == $past(i_wdata[SPFCS_BIT_BP]));
    endproperty
    a_bp_write: assert property (p_bp_write) else $error("port1 backpressure not written");
    property p_port2_read;
        (i_rd && i_addr == SPFCS_PORT2_FC_OFS)
            |=> (o_rdata[SPFCS_BIT_BP] == $past(bp_reg[1])
                 && o_rdata[SPFCS_BIT_SELECT] == $past(sel_reg[1]));
    endproperty
    a_port2_read: assert property (p_port2_read) else $error("port2 read mismatch");
    property p_duplex;
        run |=> (o_port1_duplex_status == $past(half[0]));
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex status stale");
    property p_aneg;
        (run && !sel_reg[0] && aneg_en[0])
            |=> (o_port1_rx_pause_active == $past(aneg_rx[0])
                 && o_port1_tx_pause_active == $past(aneg_tx[0]));
    endproperty
    a_aneg: assert property (p_aneg) else $error("negotiated pause not applied");
    property p_sw_no_aneg;
        (run && !sel_reg[1] && !aneg_en[1])
            |=> (o_port2_rx_pause_active == $past(rx_allow_reg[1])
                 && o_port2_tx_pause_active == $past(tx_allow_reg[1]));
    endproperty
    a_sw_no_aneg: assert property (p_sw_no_aneg) else $error("software pause not applied");
    property p_manual;
        (run && sel_reg[0])
            |=> (o_port1_tx_pause_active == ($past(tx_allow_reg[0]) & ~$past(half[0])));
    endproperty
    a_manual: assert property (p_manual) else $error("manual pause wrong");
    property p_readback;
        (i_rd && i_addr == SPFCS_PORT1_FC_OFS)
            |=> (o_rdata[SPFCS_BIT_RX_ACTIVE] == $past(o_port1_rx_pause_active)
                 && o_rdata[SPFCS_BIT_TX_ACTIVE] == $past(o_port1_tx_pause_active));
    endproperty
    a_readback: assert property (p_readback) else $error("readback not effective");
    property p_strap;
        (state_reg == SPFCS_ST_LOAD)
            |=> (sel_reg == $past(strap_sel) && bp_reg == $past(strap_bp)
                 && rx_allow_reg == $past(strap_pause));
    endproperty
    a_strap: assert property (p_strap) else $error("strap load failed");
    property p_load_time;
        (state_reg == SPFCS_ST_WAIT) |-> ##[1:3] run;
    endproperty
    a_load_time: assert property (p_load_time) else $error("strap load too slow");
    c_manual_write: cover property (run && i_wr && i_wdata[SPFCS_BIT_SELECT]);
    c_aneg_mode: cover property (run && !sel_reg[0] && aneg_en[0] && aneg_rx[0]);
    c_port2_read: cover property (i_rd && i_addr == SPFCS_PORT2_FC_OFS);
    c_half_manual: cover property (run && sel_reg[1] && half[1] && tx_allow_reg[1]);
endmodule : spfcs_top

/* bench/spfcs_tb.sv */
// self-checking bench for the switch port flow control select registers
`timescale 1ns/10ps
module testbench;
    import spfcs_pkg::*;
    logic i_mclk;
    logic i_rst_b;
    logic [11:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic [2:1] bp_pin, pause_pin, sel_pin, an_en, an_rx, an_tx, half;
    wire [2:1] o_rxe, o_txe, o_bp, o_dup;
    // bench copy of the writable bits
    logic [2:1] m_bp, m_rxa, m_txa, m_sel;
    logic [15:0] lfsr_reg;
    logic [15:0] r;
    logic [31:0] d;
    int errors, tests_run, cycles;

    spfcs_top DUT (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_port1_backpressure_pin_cfg(bp_pin[1]), .i_port1_pause_pin_cfg(pause_pin[1]),
        .i_port1_select_pin_cfg(sel_pin[1]),
        .i_port2_backpressure_pin_cfg(bp_pin[2]), .i_port2_pause_pin_cfg(pause_pin[2]),
        .i_port2_select_pin_cfg(sel_pin[2]),
        .i_port1_aneg_enable(an_en[1]), .i_port1_aneg_rx_pause(an_rx[1]),
        .i_port1_aneg_tx_pause(an_tx[1]), .i_port1_half_duplex(half[1]),
        .i_port2_aneg_enable(an_en[2]), .i_port2_aneg_rx_pause(an_rx[2]),
        .i_port2_aneg_tx_pause(an_tx[2]), .i_port2_half_duplex(half[2]),
        .o_port1_rx_pause_active(o_rxe[1]), .o_port1_tx_pause_active(o_txe[1]),
        .o_port1_backpressure_on(o_bp[1]), .o_port1_duplex_status(o_dup[1]),
        .o_port2_rx_pause_active(o_rxe[2]), .o_port2_tx_pause_active(o_txe[2]),
        .o_port2_backpressure_on(o_bp[2]), .o_port2_duplex_status(o_dup[2])
    );

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    // cut a hang short
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            $display("timeout after %0d cycles", cycles);
            errors = errors + 1;
            complete_run();
        end
    end

    function automatic logic [15:0] next_rand();
        lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        return lfsr_reg;
    endfunction : next_rand

    function automatic logic [11:0] ofs(int p);
        return (p == 1) ? SPFCS_PORT1_FC_OFS : SPFCS_PORT2_FC_OFS;
    endfunction : ofs

    // expected word from shadow bits and link inputs
    function automatic logic [31:0] exp_word(int p);
        logic rx, tx;
        rx = m_rxa[p];
        tx = m_txa[p];
        if (m_sel[p] && half[p]) begin
            rx = 1'b0;
            tx = 1'b0;
        end else if (!m_sel[p] && an_en[p]) begin
            rx = an_rx[p];
            tx = an_tx[p];
        end
        return {25'h0, m_bp[p], half[p], rx, tx, m_rxa[p], m_txa[p], m_sel[p]};
    endfunction : exp_word

    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic e, input logic g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %b seen %b", name, e, g);
        end
    endtask : check_bit

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        for (int p = 1; p <= 2; p++) begin
            if (a === ofs(p)) begin
                m_bp[p] = v[SPFCS_BIT_BP];
                m_rxa[p] = v[SPFCS_BIT_RX_ALLOW];
                m_txa[p] = v[SPFCS_BIT_TX_ALLOW];
                m_sel[p] = v[SPFCS_BIT_SELECT];
            end
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        v = o_rdata;
    endtask : rd

    task automatic set_link(input int p, input logic [3:0] v);
        an_en[p] <= v[0];
        an_rx[p] <= v[1];
        an_tx[p] <= v[2];
        half[p] <= v[3];
    endtask : set_link

    task automatic check_port(input int p);
        logic [31:0] g;
        logic [31:0] e;
        rd(ofs(p), g);
        e = exp_word(p);
        check_word("register word", e, g);
        check_bit("rx pause out", e[4], o_rxe[p]);
        check_bit("tx pause out", e[3], o_txe[p]);
        check_bit("backpressure out", e[6], o_bp[p]);
        check_bit("duplex out", e[5], o_dup[p]);
    endtask : check_port

    task automatic do_reset();
        i_rst_b <= 1'b0;
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        m_bp = bp_pin;
        m_rxa = pause_pin;
        m_txa = pause_pin;
        m_sel = sel_pin;
        repeat (8) @(posedge i_mclk);
    endtask : do_reset

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        i_rst_b = 1'b0;
        i_addr = 12'h000;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        {bp_pin, pause_pin, sel_pin} = 6'h00;
        {an_en, an_rx, an_tx, half} = 8'h00;
        lfsr_reg = 16'h0016;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        r = next_rand();
        // strap loading, pattern and its complement
        for (int k = 0; k < 2; k++) begin
            @(posedge i_mclk);
            {bp_pin, pause_pin, sel_pin} <= k ? ~r[5:0] : r[5:0];
            {an_en, an_rx, an_tx, half} <= r[15:8];
            do_reset();
            check_port(1);
            check_port(2);
        end
        $display("test strap reset done, errors %0d", errors);
        // every select, negotiation and duplex mode on each port
        for (int p = 1; p <= 2; p++) begin
            for (int m = 0; m < 8; m++) begin
                r = next_rand();
                wr(ofs(p), {r, r[15:1], m[0]});
                set_link(p, {m[2], r[8], r[7], m[1]});
                repeat (5) @(posedge i_mclk);
                check_port(p);
                check_port(3 - p);
            end
        end
        $display("test mode table done, errors %0d", errors);
        // unmapped places and idle read data
        wr(12'h1a8, 32'hffff_ffff);
        wr(12'h1a1, 32'hffff_ffff);
        rd(12'h1a8, d);
        check_word("unmapped read", 32'h0000_0000, d);
        @(negedge i_mclk);
        check_word("idle read data", 32'h0000_0000, o_rdata);
        check_port(1);
        check_port(2);
        $display("test unmapped done, errors %0d", errors);
        // random traffic on both ports
        for (int n = 0; n < 30; n++) begin
            r = next_rand();
            d = {r[7:0], r, r[15:8]};
            wr(ofs(1), d);
            wr(ofs(2), ~d);
            set_link(1, r[3:0]);
            set_link(2, r[7:4]);
            repeat (5) @(posedge i_mclk);
            check_port(1);
            check_port(2);
        end
        $display("test random done, errors %0d", errors);
        complete_run();
    end
endmodule : testbench
